// ### include/qstc_cfg.svh
// Offsets, field positions, reset values and divider counts of the quarter-second counter
`ifndef QSTC_CFG_SVH
`define QSTC_CFG_SVH

// ==========================================================================
// Register byte offsets
`define QSTC_OFF_CTRL 8'h00
`define QSTC_OFF_STAT 8'h04
`define QSTC_OFF_MATCH 8'h08
`define QSTC_OFF_COUNT 8'h0C

// ==========================================================================
// Control register fields
`define QSTC_CTRL_EN 7
`define QSTC_CTRL_CLKS_MSB 6
`define QSTC_CTRL_CLKS_LSB 5
`define QSTC_CTRL_RST 4
`define QSTC_CTRL_CLKEN 3
`define QSTC_CTRL_PS_MSB 2
`define QSTC_CTRL_PS_LSB 0

// ==========================================================================
// Status register fields
`define QSTC_STAT_QUARTER_SEC_FLAG 7
`define QSTC_STAT_ONE_SEC_FLAG 6
`define QSTC_STAT_MATCH_FLAG 5
`define QSTC_STAT_QIE 4
`define QSTC_STAT_SIE 3
`define QSTC_STAT_MIE 2
`define QSTC_STAT_MEN 1
`define QSTC_STAT_MWP 0

// ==========================================================================
// Match register fields
`define QSTC_MATCH_MSB 7
`define QSTC_MATCH_LSB 2

// ==========================================================================
// Reset values
`define QSTC_RST_PS 3'h1
`define QSTC_RST_CLKS 2'h0

// ==========================================================================
// Clock source codes
`define QSTC_CLKS_EXT 2'h0
`define QSTC_CLKS_LPO 2'h1
`define QSTC_CLKS_IREF 2'h2

// ==========================================================================
// First-stage dividers (high frequency inputs down to the output clock)
`define QSTC_PRE_NONE 10'h001
`define QSTC_PRE_4M9 10'h080
`define QSTC_PRE_4M 10'h07D
`define QSTC_PRE_8M 10'h0FA
`define QSTC_PRE_16M 10'h1F4

// ==========================================================================
// Second-stage dividers (output clock down to 4 Hz)
`define QSTC_QTR_1K 14'h00FA
`define QSTC_QTR_32K768 14'h2000
`define QSTC_QTR_32K 14'h1F40
`define QSTC_QTR_38K4 14'h2580

// ==========================================================================
// Match write completion time, in aclk cycles
`define QSTC_MWR_CYCLES 2'h2

// ==========================================================================
// AXI responses
`define QSTC_RESP_OKAY 2'h0
`define QSTC_RESP_SLVERR 2'h2

`endif

// ### include/qstc_pkg.sv
// Types shared by the quarter-second counter
package qstc_pkg;

  // Software control fields
  typedef struct packed {
    logic module_enable;
    logic [1:0] clock_source_select;
    logic clock_output_enable;
    logic [2:0] prescale_select;
  } qstc_ctrl_t;

  // Event flags and their enables
  typedef struct packed {
    logic quarter_sec_flag;
    logic one_sec_flag;
    logic match_flag;
    logic quarter_sec_irq_enable;
    logic one_sec_irq_enable;
    logic match_irq_enable;
    logic match_function_enable;
  } qstc_stat_t;

endpackage : qstc_pkg

// ### verilog/qstc_top.sv
// Quarter-second time counter with AXI4-Lite register slave
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "qstc_cfg.svh"

module qstc_top (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Reference clock inputs, sampled as levels
  input wire logic external_osc_clock,
  input wire logic low_power_1khz_osc,
  input wire logic internal_reference_clock,
  // Outputs to the system
  output logic clock_output,
  output logic irq
);
  import qstc_pkg::*;

  // ==========================================================================
  // State
  qstc_ctrl_t ctrl_q;
  qstc_stat_t stat_q;
  logic [7:0] quarter_second_counter_q;
  logic [5:0] match_value_q;
  logic [1:0] match_low_bits_q;
  logic [1:0] mwp_cnt_q;
  logic [2:0] sync_q;
  logic [9:0] pre_cnt_q;
  logic [13:0] qtr_cnt_q;
  logic clock_output_q;
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // ==========================================================================
  // AXI write channel acceptance; address and data may come in either order
  // Each slot frees only on the response handshake, so a second write waits for bready
  // Only the low byte lane carries register data; a cleared wstrb[0] changes nothing
  // but the response still follows the address decode
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready = !w_held_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  wire aw_take = s_axi_awvalid && !aw_held_q;
  wire w_take = s_axi_wvalid && !w_held_q;
  wire wr_go = aw_held_q && w_held_q && !bvalid_q;
  wire wr_lane = wr_go && wstrb0_q;
  wire wr_ctrl = wr_lane && (awaddr_q == `QSTC_OFF_CTRL);
  wire wr_stat = wr_lane && (awaddr_q == `QSTC_OFF_STAT);
  wire wr_match = wr_lane && (awaddr_q == `QSTC_OFF_MATCH);
  wire wr_hit = (awaddr_q == `QSTC_OFF_CTRL) || (awaddr_q == `QSTC_OFF_STAT) ||
                (awaddr_q == `QSTC_OFF_MATCH) || (awaddr_q == `QSTC_OFF_COUNT);

  // Captures address and data; both slots free once the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
      end else if (bvalid_q && s_axi_bready) begin
        aw_held_q <= 1'b0;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end else if (bvalid_q && s_axi_bready) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response, one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `QSTC_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? `QSTC_RESP_OKAY : `QSTC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Read path; counter-reset bit always reads zero
  // Data is captured at the address handshake and held, so a tick that lands
  // while rvalid waits for rready does not change the answer
  wire [7:0] ctrl_rd = {ctrl_q.module_enable, ctrl_q.clock_source_select, 1'b0,
                        ctrl_q.clock_output_enable, ctrl_q.prescale_select};
  wire mwp = (mwp_cnt_q != 2'h0);
  wire [7:0] stat_rd = {stat_q.quarter_sec_flag, stat_q.one_sec_flag, stat_q.match_flag,
                        stat_q.quarter_sec_irq_enable, stat_q.one_sec_irq_enable,
                        stat_q.match_irq_enable, stat_q.match_function_enable, mwp};
  wire [7:0] araddr_w = {s_axi_araddr[7:2], 2'h0};
  wire rd_hit = (araddr_w == `QSTC_OFF_CTRL) || (araddr_w == `QSTC_OFF_STAT) ||
                (araddr_w == `QSTC_OFF_MATCH) || (araddr_w == `QSTC_OFF_COUNT);
  wire [7:0] rd_byte = (araddr_w == `QSTC_OFF_CTRL) ? ctrl_rd :
                       (araddr_w == `QSTC_OFF_STAT) ? stat_rd :
                       (araddr_w == `QSTC_OFF_MATCH) ? {match_value_q, match_low_bits_q} :
                       (araddr_w == `QSTC_OFF_COUNT) ? quarter_second_counter_q : 8'h00;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Read data registered; unmapped reads give zero with a slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `QSTC_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= rd_hit ? `QSTC_RESP_OKAY : `QSTC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Control register; reset defaults suit a 32.768 kHz input
  // Source and prescale take any write; keeping them still while enabled is up to
  // software, the logic does not guard it
  // The reset command is not stored, it lasts only for the write cycle
  wire counter_reset_cmd = wr_ctrl && wdata_q[`QSTC_CTRL_RST];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q.module_enable <= 1'b0;
      ctrl_q.clock_source_select <= `QSTC_RST_CLKS;
      ctrl_q.clock_output_enable <= 1'b0;
      ctrl_q.prescale_select <= `QSTC_RST_PS;
    end else if (wr_ctrl) begin
      ctrl_q.module_enable <= wdata_q[`QSTC_CTRL_EN];
      ctrl_q.clock_source_select <= wdata_q[`QSTC_CTRL_CLKS_MSB:`QSTC_CTRL_CLKS_LSB];
      ctrl_q.clock_output_enable <= wdata_q[`QSTC_CTRL_CLKEN];
      ctrl_q.prescale_select <= wdata_q[`QSTC_CTRL_PS_MSB:`QSTC_CTRL_PS_LSB];
    end
  end

  // ==========================================================================
  // Source selection and synchroniser; stage 0 feeds only stage 1, the logic reads stages 1 and 2
  // Levels are sampled by aclk, so every reference must stay below half the aclk rate
  // A source code with no input behind it holds the level low and freezes the count
  wire src_level = (ctrl_q.clock_source_select == `QSTC_CLKS_EXT) ? external_osc_clock :
                   (ctrl_q.clock_source_select == `QSTC_CLKS_LPO) ? low_power_1khz_osc :
                   (ctrl_q.clock_source_select == `QSTC_CLKS_IREF) ? internal_reference_clock :
                   1'b0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= {sync_q[1:0], src_level};
    end
  end
  wire src_edge = sync_q[1] && !sync_q[2];

  // ==========================================================================
  // Divider selection per prescale code
  // High-rate inputs first come down to the output clock rate, then the
  // second divider brings that rate down to 4 Hz
  logic [9:0] pre_div;
  logic [13:0] qtr_div;
  always_comb begin
    case (ctrl_q.prescale_select)
      3'h0: begin
        pre_div = `QSTC_PRE_NONE;
        qtr_div = `QSTC_QTR_1K;
      end
      3'h1: begin
        pre_div = `QSTC_PRE_NONE;
        qtr_div = `QSTC_QTR_32K768;
      end
      3'h2: begin
        pre_div = `QSTC_PRE_NONE;
        qtr_div = `QSTC_QTR_32K;
      end
      3'h3: begin
        pre_div = `QSTC_PRE_NONE;
        qtr_div = `QSTC_QTR_38K4;
      end
      3'h4: begin
        pre_div = `QSTC_PRE_4M9;
        qtr_div = `QSTC_QTR_38K4;
      end
      3'h5: begin
        pre_div = `QSTC_PRE_4M;
        qtr_div = `QSTC_QTR_32K;
      end
      3'h6: begin
        pre_div = `QSTC_PRE_8M;
        qtr_div = `QSTC_QTR_32K;
      end
      default: begin
        pre_div = `QSTC_PRE_16M;
        qtr_div = `QSTC_QTR_32K;
      end
    endcase
  end

  // ==========================================================================
  // Two-stage prescaler; disable or reset command restarts it from zero
  // Clearing both stages makes the first tick a full quarter second after a restart
  // Both stages advance only on detected input edges
  wire run = ctrl_q.module_enable && !counter_reset_cmd;
  wire pre_tick = src_edge && (pre_cnt_q == pre_div - 10'h001);
  wire tick = pre_tick && (qtr_cnt_q == qtr_div - 14'h0001);
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      pre_cnt_q <= 10'h000;
      qtr_cnt_q <= 14'h0000;
    end else begin
      if (src_edge) begin
        pre_cnt_q <= pre_tick ? 10'h000 : pre_cnt_q + 10'h001;
      end
      if (pre_tick) begin
        qtr_cnt_q <= tick ? 14'h0000 : qtr_cnt_q + 14'h0001;
      end
    end
  end

  // ==========================================================================
  // Clock output: pass-through for low inputs except prescale code 0, which stays low; half-duty square after the first divider
  // Made in aclk, so it carries one aclk period of jitter; fine for slow peripherals,
  // not a true clock
  wire clkout_level = (pre_div == `QSTC_PRE_NONE) ? sync_q[1] : (pre_cnt_q < (pre_div >> 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_output_q <= 1'b0;
    end else begin
      clock_output_q <= ctrl_q.module_enable && ctrl_q.clock_output_enable &&
                        (ctrl_q.prescale_select != 3'h0) && clkout_level;
    end
  end
  assign clock_output = clock_output_q;

  // ==========================================================================
  // Counter and match; match is only seen on a tick, so a reset to zero never matches
  // Comparing the incremented value lands the match and the new count on one edge
  // Only the upper six bits clear, so the quarter phase and one-second cadence survive
  // A match value moved close to the running count may still fire once at the old value
  wire [7:0] cnt_inc = quarter_second_counter_q + 8'h01;
  wire match_hit = tick && stat_q.match_function_enable &&
                   (cnt_inc == {match_value_q, match_low_bits_q});
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      quarter_second_counter_q <= 8'h00;
    end else if (match_hit) begin
      quarter_second_counter_q <= {6'h00, cnt_inc[1:0]};
    end else if (tick) begin
      quarter_second_counter_q <= cnt_inc;
    end
  end

  // Match register; writes while pending are dropped
  // The low bits copy the running count at the accepted write, which keeps
  // repeated matches aligned to the quarter phase at which software armed them
  wire match_accept = wr_match && !mwp;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_value_q <= 6'h00;
      match_low_bits_q <= 2'h0;
    end else if (match_accept) begin
      match_value_q <= wdata_q[`QSTC_MATCH_MSB:`QSTC_MATCH_LSB];
      match_low_bits_q <= quarter_second_counter_q[1:0];
    end
  end

  // Write-pending counts down the completion time
  // Short, fixed window; software writing twice in a row polls it first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mwp_cnt_q <= 2'h0;
    end else if (match_accept) begin
      mwp_cnt_q <= `QSTC_MWR_CYCLES;
    end else if (mwp) begin
      mwp_cnt_q <= mwp_cnt_q - 2'h1;
    end
  end

  // ==========================================================================
  // Flags: set wins over write-one-to-clear
  // Keeping the set means an event in the clearing cycle is never lost
  // The enables are plain read-write bits written by the same store
  wire qsec_set = tick;
  wire sec_set = tick && (cnt_inc[1:0] == 2'h0);
  wire clr_q = wr_stat && wdata_q[`QSTC_STAT_QUARTER_SEC_FLAG];
  wire clr_s = wr_stat && wdata_q[`QSTC_STAT_ONE_SEC_FLAG];
  wire clr_m = wr_stat && wdata_q[`QSTC_STAT_MATCH_FLAG];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
    end else begin
      stat_q.quarter_sec_flag <= qsec_set || (stat_q.quarter_sec_flag && !clr_q);
      stat_q.one_sec_flag <= sec_set || (stat_q.one_sec_flag && !clr_s);
      stat_q.match_flag <= match_hit || (stat_q.match_flag && !clr_m);
      if (wr_stat) begin
        stat_q.quarter_sec_irq_enable <= wdata_q[`QSTC_STAT_QIE];
        stat_q.one_sec_irq_enable <= wdata_q[`QSTC_STAT_SIE];
        stat_q.match_irq_enable <= wdata_q[`QSTC_STAT_MIE];
        stat_q.match_function_enable <= wdata_q[`QSTC_STAT_MEN];
      end
    end
  end

  // One request line: simultaneous flags merge into a single level
  // The line stays high until every enabled flag has been cleared
  assign irq = (stat_q.quarter_sec_flag && stat_q.quarter_sec_irq_enable) ||
               (stat_q.one_sec_flag && stat_q.one_sec_irq_enable) ||
               (stat_q.match_flag && stat_q.match_irq_enable);

endmodule : qstc_top
`default_nettype wire

// ### testbench/qstc_top_sva.sv
// Port checker for the quarter-second counter
`timescale 1ns/1ps
`default_nettype none
`include "qstc_cfg.svh"
module qstc_top_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic clock_output,
  input wire logic irq
);
  // ==========================================================================
  // Address of the read under way, so the answer can be judged per register
  logic [7:0] rd_addr_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr_q <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_q <= s_axi_araddr;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // Reset, register and bus checks
  a_reset_quiet:
    assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && !clock_output)
    else $error("outputs not quiet after reset");
  a_cmd_reads_zero:
    assert property (s_axi_rvalid && rd_addr_q == `QSTC_OFF_CTRL |-> !s_axi_rdata[`QSTC_CTRL_RST])
    else $error("counter reset command read back as one");
  a_unmapped_read:
    assert property (s_axi_rvalid && rd_addr_q[7:4] != 4'h0 |-> s_axi_rresp == `QSTC_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_read:
    assert property (s_axi_rvalid && rd_addr_q[7:4] == 4'h0 |-> s_axi_rresp == `QSTC_RESP_OKAY && s_axi_rdata[31:8] == 24'h0)
    else $error("mapped read answer malformed");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid)
    else $error("read answer late");
  a_read_busy:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_write_busy:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");

  // Main scenarios reached
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == `QSTC_RESP_SLVERR);
  c_irq: cover property ($rose(irq));
  c_clkout: cover property ($rose(clock_output));
endmodule : qstc_top_sva

bind qstc_top qstc_top_sva u_sva (.*);
`default_nettype wire

// ### testbench/qstc_top_tb_top.sv
// Self-checking bench for the quarter-second counter
`timescale 1ns/1ps
`default_nettype none
`include "qstc_cfg.svh"
module qstc_top_tb_top;
  logic aclk = 1'b0;
  logic ref_tog = 1'b0;
  logic ref_ph = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, clock_output, irq;
  logic external_osc_clock, low_power_1khz_osc, internal_reference_clock;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int n_errors, samples_checked, t0;
  int cyc = 0;

  qstc_top u_dut (.*);

  // ==========================================================================
  // Clock, and a slow reference with one rising edge every four cycles
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    ref_ph <= ~ref_ph;
    if (ref_ph) ref_tog <= ~ref_tog;
  end
  // Internal reference stays idle so a wrong source shows as a stalled count
  assign external_osc_clock = ref_tog;
  assign low_power_1khz_osc = ref_tog;
  assign internal_reference_clock = 1'b0;

  // ==========================================================================
  // Reporting
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic tmo();
    n_errors++;
    $display("CHECK FAILED wait expected answer seen none");
    stop_test();
  endtask : tmo

  // ==========================================================================
  // Bus master; readies sampled at the falling edge, where they are settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    logic aw_t, w_t, b;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    for (n = 0; n < 50 && !b; n++) begin
      @(negedge aclk);
      b = s_axi_bvalid;
      rsp = s_axi_bresp;
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!b) tmo();
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    int n;
    logic ar_t, r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r = 1'b0;
    for (n = 0; n < 50 && !r; n++) begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!r) tmo();
  endtask : rd_reg

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a);
    check(nm, rd, exp);
  endtask : rchk

  // Polls a register until the masked byte matches; bounded
  task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
    int n;
    rd_reg(a);
    for (n = 0; n < 3000 && (rd[7:0] & m) !== v; n++) rd_reg(a);
    if ((rd[7:0] & m) !== v) tmo();
  endtask : poll

  task automatic out_edges(input logic exp_some);
    int t;
    logic p;
    t = 0;
    @(negedge aclk);
    p = clock_output;
    repeat (200) begin
      @(negedge aclk);
      if (clock_output !== p) t++;
      p = clock_output;
    end
    check("clock output active", {31'h0, t > 0}, {31'h0, exp_some});
  endtask : out_edges

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rchk("ctrl", `QSTC_OFF_CTRL, 32'h01);
    rchk("stat", `QSTC_OFF_STAT, 32'h00);
    rchk("match", `QSTC_OFF_MATCH, 32'h00);
    rchk("count", `QSTC_OFF_COUNT, 32'h00);
    rchk("unmapped", 8'h10, 32'h00);
    check("unmapped resp", {30'h0, rsp}, {30'h0, `QSTC_RESP_SLVERR});
    wr(8'h10, 8'hFF);
    check("unmapped write resp", {30'h0, rsp}, {30'h0, `QSTC_RESP_SLVERR});
    rchk("ctrl after unmapped write", `QSTC_OFF_CTRL, 32'h01);
  endtask : t_reset

  task automatic t_source();
    wr(`QSTC_OFF_CTRL, 8'h40);
    check("write resp", {30'h0, rsp}, {30'h0, `QSTC_RESP_OKAY});
    wr(`QSTC_OFF_CTRL, 8'hC0);
    repeat (3000) @(posedge aclk);
    rchk("count idle source", `QSTC_OFF_COUNT, 32'h00);
    wr(`QSTC_OFF_CTRL, 8'h40);
    wr(`QSTC_OFF_CTRL, 8'h20);
    wr(`QSTC_OFF_CTRL, 8'hA0);
  endtask : t_source

  task automatic t_count();
    poll(`QSTC_OFF_COUNT, 8'hFF, 8'h01);
    t0 = cyc;
    poll(`QSTC_OFF_COUNT, 8'hFF, 8'h02);
    check("tick period", {31'h0, cyc - t0 >= 990 && cyc - t0 <= 1010}, 32'h1);
    rchk("flags at two", `QSTC_OFF_STAT, 32'h80);
    wr(`QSTC_OFF_STAT, 8'hD8);
    check("irq cleared", {31'h0, irq}, 32'h0);
    poll(`QSTC_OFF_COUNT, 8'hFF, 8'h04);
    rchk("flags at second", `QSTC_OFF_STAT, 32'hD8);
    check("irq second", {31'h0, irq}, 32'h1);
    wr(`QSTC_OFF_STAT, 8'h98);
    check("irq one flag left", {31'h0, irq}, 32'h1);
    wr(`QSTC_OFF_STAT, 8'h58);
    check("irq all clear", {31'h0, irq}, 32'h0);
    wr(`QSTC_OFF_STAT, 8'h00);
    poll(`QSTC_OFF_COUNT, 8'hFF, 8'h05);
    rchk("flag without enable", `QSTC_OFF_STAT, 32'h80);
    check("irq masked", {31'h0, irq}, 32'h0);
  endtask : t_count

  task automatic t_reset_cmd();
    wr(`QSTC_OFF_CTRL, 8'hB0);
    t0 = cyc;
    rchk("count after cmd", `QSTC_OFF_COUNT, 32'h00);
    rchk("cmd reads zero", `QSTC_OFF_CTRL, 32'hA0);
    poll(`QSTC_OFF_COUNT, 8'hFF, 8'h01);
    check("restart period", {31'h0, cyc - t0 >= 985 && cyc - t0 <= 1015}, 32'h1);
  endtask : t_reset_cmd

  task automatic t_match();
    wr(`QSTC_OFF_MATCH, 8'hFC);
    rchk("match all ones", `QSTC_OFF_MATCH, 32'hFD);
    // Status read lands just after the match write is accepted
    fork
      wr(`QSTC_OFF_MATCH, 8'h08);
      begin
        repeat (2) @(posedge aclk);
        rchk("write pending", `QSTC_OFF_STAT, 32'h81);
      end
    join
    rchk("match low copy", `QSTC_OFF_MATCH, 32'h09);
    rchk("write done", `QSTC_OFF_STAT, 32'h80);
    wr(`QSTC_OFF_STAT, 8'h22);
    poll(`QSTC_OFF_STAT, 8'h20, 8'h20);
    t0 = cyc;
    rchk("count after match", `QSTC_OFF_COUNT, 32'h01);
    wr(`QSTC_OFF_STAT, 8'hE6);
    check("irq before match", {31'h0, irq}, 32'h0);
    poll(`QSTC_OFF_STAT, 8'h20, 8'h20);
    check("match spacing", {31'h0, cyc - t0 >= 7980 && cyc - t0 <= 8020}, 32'h1);
    check("irq on match", {31'h0, irq}, 32'h1);
    wr(`QSTC_OFF_STAT, 8'hE0);
    check("irq match cleared", {31'h0, irq}, 32'h0);
  endtask : t_match

  task automatic t_clkout();
    wr(`QSTC_OFF_CTRL, 8'h20);
    wr(`QSTC_OFF_CTRL, 8'h09);
    wr(`QSTC_OFF_CTRL, 8'h89);
    out_edges(1'b1);
    wr(`QSTC_OFF_CTRL, 8'h81);
    out_edges(1'b0);
    wr(`QSTC_OFF_CTRL, 8'h01);
    wr(`QSTC_OFF_CTRL, 8'h08);
    wr(`QSTC_OFF_CTRL, 8'h88);
    out_edges(1'b0);
  endtask : t_clkout

  // ==========================================================================
  // Main sequence
  initial begin
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    n_errors = 0;
    samples_checked = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_source();
    t_count();
    t_reset_cmd();
    t_match();
    t_clkout();
    stop_test();
  end
endmodule : qstc_top_tb_top
`default_nettype wire
